//--- rtl/input_terminal_function_router.sv
// Routes eight input terminals and remote inputs onto motion command functions
//
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module input_terminal_function_router
    import in_router_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [NUM_TERM-1:0] i_input_terminal,
    input wire logic i_remote_valid,
    input wire logic [NUM_FUNC-1:0] i_remote_func,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hsel,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic o_cont_positive_req,
    output logic o_cont_negative_req,
    output logic o_home_req,
    output logic o_position_req,
    output logic o_sequential_pos_req,
    output logic o_inch_positive_req,
    output logic o_inch_negative_req,
    output logic [NUM_DIRECT-1:0] o_direct_pos_select,
    output logic o_free_run,
    output logic o_excitation_on,
    output logic o_halt,
    output logic o_alarm_clear,
    output logic o_position_preset,
    output logic o_abs_error_clear,
    output logic o_lockout_release,
    output logic [NUM_GENERAL-1:0] o_general_signal,
    output logic [NUM_DATA_SEL-1:0] o_data_select
);
    logic [NUM_TERM*CODE_W-1:0] codes_r;
    logic [NUM_TERM-1:0] polarity_r;
    logic [NUM_FUNC-1:0] remote_r;
    logic remote_en_r;
    logic [NUM_TERM-1:0] term_active;
    logic [NUM_FUNC-1:0] dir_func;
    logic [NUM_FUNC-1:0] dir_assigned;
    logic [NUM_FUNC-1:0] rem_func;
    logic [NUM_FUNC-1:0] func;
    logic excite_lvl;
    logic lockout_lvl;
    logic alarm_fall;
    logic abs_fall;
    logic preset_rise;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [7:0] rd_addr;
    logic bus_go;
    logic [NUM_TERM*CODE_W-1:0] codes_nxt;
    logic [NUM_TERM-1:0] polarity_nxt;
    logic remote_en_nxt;
    logic [31:0] hrdata_nxt;

    // Per-terminal polarity, normally closed inverts
    assign term_active = i_input_terminal ^ polarity_r; // [RULE20]

    in_router_decode u_decode
    (
        .i_codes(codes_r),
        .i_active(term_active),
        .o_func(dir_func),
        .o_assigned(dir_assigned)
    );

    // Remote inputs carry the same function numbering
    assign rem_func = remote_en_r ? remote_r : '0; // [RULE16]

    // AND of present sources, an absent source reads active
    function automatic logic both_sources(input logic dir_on, input logic dir_set,
        input logic rem_on, input logic rem_set);
        both_sources = (dir_set ? dir_on : 1'b1) & (rem_set ? rem_on : 1'b1);
    endfunction

    always_comb
    begin
        func = dir_func | rem_func; // [RULE17]
        excite_lvl = both_sources(dir_func[CODE_EXCITE], dir_assigned[CODE_EXCITE],
            remote_r[CODE_EXCITE], remote_en_r); // [RULE19]
        lockout_lvl = both_sources(dir_func[CODE_LOCKOUT_REL], dir_assigned[CODE_LOCKOUT_REL],
            remote_r[CODE_LOCKOUT_REL], remote_en_r); // [RULE19]
    end

    in_router_edge u_alarm_edge
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(func[CODE_ALARM_CLR]),
        .o_rise(),
        .o_fall(alarm_fall)
    );

    in_router_edge u_abs_edge
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(func[CODE_ABS_CLR]),
        .o_rise(),
        .o_fall(abs_fall)
    );

    in_router_edge u_preset_edge
    (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_level(func[CODE_PRESET]),
        .o_rise(preset_rise),
        .o_fall()
    );

    // Motion requests
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cont_positive_req <= 1'b0;
            o_cont_negative_req <= 1'b0;
            o_home_req <= 1'b0;
            o_position_req <= 1'b0;
            o_sequential_pos_req <= 1'b0;
            o_inch_positive_req <= 1'b0;
            o_inch_negative_req <= 1'b0;
            o_direct_pos_select <= '0;
        end
        else
        begin
            o_cont_positive_req <= func[CODE_CONT_POS]; // [RULE4]
            o_cont_negative_req <= func[CODE_CONT_NEG]; // [RULE4]
            o_home_req <= func[CODE_HOME]; // [RULE5]
            o_position_req <= func[CODE_POSITION]; // [RULE5]
            o_sequential_pos_req <= func[CODE_SEQ_POS]; // [RULE5]
            o_inch_positive_req <= func[CODE_INCH_POS]; // [RULE6]
            o_inch_negative_req <= func[CODE_INCH_NEG]; // [RULE6]
            o_direct_pos_select <= func[CODE_DIRECT_0 +: NUM_DIRECT]; // [RULE7]
        end
    end

    // Excitation, brake, stop and lockout levels
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_free_run <= 1'b0;
            o_excitation_on <= 1'b0;
            o_halt <= 1'b0;
            o_lockout_release <= 1'b0;
        end
        else
        begin
            o_free_run <= func[CODE_FREE_RUN]; // [RULE8]
            o_excitation_on <= excite_lvl; // [RULE9]
            o_halt <= func[CODE_HALT]; // [RULE10]
            o_lockout_release <= lockout_lvl; // [RULE13]
        end
    end

    // General signals and operation data number
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_general_signal <= '0;
            o_data_select <= '0;
        end
        else
        begin
            o_general_signal <= func[CODE_GENERAL_0 +: NUM_GENERAL]; // [RULE14]
            o_data_select <= func[CODE_DATA_SEL_0 +: NUM_DATA_SEL]; // [RULE15]
        end
    end

    // One-cycle action pulses
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_alarm_clear <= 1'b0;
        else
            o_alarm_clear <= alarm_fall; // [RULE11] [RULE18]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_abs_error_clear <= 1'b0;
        else
            o_abs_error_clear <= abs_fall; // [RULE12] [RULE18]
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_position_preset <= 1'b0;
        else
            o_position_preset <= preset_rise; // [RULE12] [RULE18]
    end

    // AHB-Lite slave, zero wait states
    assign bus_go = i_hsel & i_hready & i_htrans[1];
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign rd_addr = i_haddr[7:0];

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end
        else
        begin
            wr_pend_r <= bus_go & i_hwrite;
            wr_addr_r <= i_haddr[7:0];
        end
    end

    function automatic logic [23:0] unpack4(input logic [31:0] w);
        unpack4 = {w[29:24], w[21:16], w[13:8], w[5:0]};
    endfunction

    // Next configuration; a write lands at the end of its data phase
    always_comb
    begin
        codes_nxt = codes_r;
        polarity_nxt = polarity_r;
        remote_en_nxt = remote_en_r;
        if (wr_pend_r)
        begin
            unique case (wr_addr_r)
                ADDR_CODE_LO:
                    codes_nxt[23:0] = unpack4(i_hwdata); // [RULE22]
                ADDR_CODE_HI:
                    codes_nxt[47:24] = unpack4(i_hwdata); // [RULE22]
                ADDR_POLARITY:
                    polarity_nxt = i_hwdata[NUM_TERM-1:0]; // [RULE20]
                ADDR_REMOTE:
                    remote_en_nxt = i_hwdata[0]; // [RULE16]
                default:
                    ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            codes_r <= CODE_RESET; // [RULE2]
            polarity_r <= POLARITY_RESET;
            remote_en_r <= 1'b0;
        end
        else
        begin
            codes_r <= codes_nxt;
            polarity_r <= polarity_nxt;
            remote_en_r <= remote_en_nxt;
        end
    end

    // A bus write in the same cycle wins over a remote update
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            remote_r <= '0;
        else if (!wr_pend_r && i_remote_valid)
            remote_r <= i_remote_func; // [RULE16]
    end

    function automatic logic [31:0] pack4(input logic [23:0] f);
        pack4 = {2'h0, f[23:18], 2'h0, f[17:12], 2'h0, f[11:6], 2'h0, f[5:0]};
    endfunction

    // Writable registers read from next-state values, so a read right behind a write sees it
    always_comb
    begin
        hrdata_nxt = o_hrdata;
        if (bus_go && !i_hwrite)
        begin
            unique case (rd_addr)
                ADDR_CODE_LO: hrdata_nxt = pack4(codes_nxt[23:0]);
                ADDR_CODE_HI: hrdata_nxt = pack4(codes_nxt[47:24]);
                ADDR_POLARITY: hrdata_nxt = {24'h0, polarity_nxt};
                ADDR_REMOTE: hrdata_nxt = {31'h0, remote_en_nxt};
                ADDR_STATUS: hrdata_nxt = {16'h0, term_active,
                    2'h0, o_data_select};
                ADDR_GENERAL: hrdata_nxt = {16'h0, o_general_signal};
                default: hrdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_hrdata <= '0;
        else
            o_hrdata <= hrdata_nxt;
    end
endmodule

//--- rtl/in_router_pkg.sv
// Constants for the input terminal function router
// Overview of operation
// [RULE1] Eight input terminals, each routed by its own assignment code.
// [RULE2] Reset codes for terminals 0..7: 3,4,48,49,50,16,18,24.
// [RULE3] Code 0 leaves the terminal unused.
// [RULE4] Codes 1 and 2 request continuous motion positive and negative.
// [RULE5] Codes 3,4,5 request homing, positioning and sequential positioning.
// [RULE6] Codes 6 and 7 request inching positive and negative.
// [RULE7] Codes 8 to 13 start six direct positioning operations.
// [RULE8] Code 16 is free-run: excitation off, brake released.
// [RULE9] Code 17 is excitation control.
// [RULE10] Code 18 is halt.
// [RULE11] Code 24 clears the latched alarm.
// [RULE12] Code 25 presets position; code 26 clears absolute-error alarm.
// [RULE13] Code 27 lifts the configuration-tool lockout.
// [RULE14] Codes 32 to 47 are sixteen general signals.
// [RULE15] Codes 48 to 53 form the six-bit operation data number.
// [RULE16] The same functions also arrive as remote inputs over serial.
// [RULE17] A function on several terminals is active if any is active.
// [RULE18] Alarm and abs-error clears act on fall; preset acts on rise.
// [RULE19] Unassigned excitation or lockout reads active; both sources must agree.
// [RULE20] Per-terminal polarity: 0 normally open, 1 normally closed.
// [RULE21] Unlisted codes are treated as no function.
// [RULE22] Codes sit in six-bit fields writable at run time.
package in_router_pkg;
    localparam int NUM_TERM = 8;
    localparam int CODE_W = 6;
    localparam int NUM_FUNC = 64;
    localparam logic [CODE_W-1:0] CODE_NONE = 6'h00;
    localparam logic [CODE_W-1:0] CODE_CONT_POS = 6'h01;
    localparam logic [CODE_W-1:0] CODE_CONT_NEG = 6'h02;
    localparam logic [CODE_W-1:0] CODE_HOME = 6'h03;
    localparam logic [CODE_W-1:0] CODE_POSITION = 6'h04;
    localparam logic [CODE_W-1:0] CODE_SEQ_POS = 6'h05;
    localparam logic [CODE_W-1:0] CODE_INCH_POS = 6'h06;
    localparam logic [CODE_W-1:0] CODE_INCH_NEG = 6'h07;
    localparam logic [CODE_W-1:0] CODE_DIRECT_0 = 6'h08;
    localparam logic [CODE_W-1:0] CODE_FREE_RUN = 6'h10;
    localparam logic [CODE_W-1:0] CODE_EXCITE = 6'h11;
    localparam logic [CODE_W-1:0] CODE_HALT = 6'h12;
    localparam logic [CODE_W-1:0] CODE_ALARM_CLR = 6'h18;
    localparam logic [CODE_W-1:0] CODE_PRESET = 6'h19;
    localparam logic [CODE_W-1:0] CODE_ABS_CLR = 6'h1a;
    localparam logic [CODE_W-1:0] CODE_LOCKOUT_REL = 6'h1b;
    localparam logic [CODE_W-1:0] CODE_GENERAL_0 = 6'h20;
    localparam logic [CODE_W-1:0] CODE_DATA_SEL_0 = 6'h30;
    localparam int NUM_DIRECT = 6;
    localparam int NUM_GENERAL = 16;
    localparam int NUM_DATA_SEL = 6;
    // Default code per terminal, terminal 0 in the low field
    localparam logic [NUM_TERM*CODE_W-1:0] CODE_RESET =
        {6'h18, 6'h12, 6'h10, 6'h32, 6'h31, 6'h30, 6'h04, 6'h03};
    localparam logic [NUM_TERM-1:0] POLARITY_RESET = 8'h00;
    // AHB register map (byte addresses)
    localparam logic [7:0] ADDR_CODE_LO = 8'h00;
    localparam logic [7:0] ADDR_CODE_HI = 8'h04;
    localparam logic [7:0] ADDR_POLARITY = 8'h08;
    localparam logic [7:0] ADDR_REMOTE = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_GENERAL = 8'h14;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

//--- rtl/in_router_decode.sv
// Code-to-function decoder for all terminals, with OR-combining
`timescale 1ns/1ns
module in_router_decode
    import in_router_pkg::*;
(
    input wire logic [NUM_TERM*CODE_W-1:0] i_codes,
    input wire logic [NUM_TERM-1:0] i_active,
    output logic [NUM_FUNC-1:0] o_func,
    output logic [NUM_FUNC-1:0] o_assigned
);
    function automatic logic code_valid(input logic [CODE_W-1:0] c);
        code_valid = (c >= 6'h01 && c <= 6'h0d) || (c >= 6'h10 && c <= 6'h12)
            || (c >= 6'h18 && c <= 6'h1b) || (c >= 6'h20 && c <= 6'h35); // [RULE21]
    endfunction

    always_comb
    begin
        logic [CODE_W-1:0] c;
        c = '0;
        o_func = '0;
        o_assigned = '0;
        for (int t = 0; t < NUM_TERM; t++)
        begin
            c = i_codes[t*CODE_W +: CODE_W]; // [RULE1]
            if (c != CODE_NONE && code_valid(c)) // [RULE3] [RULE21]
            begin
                o_assigned[c] = 1'b1;
                o_func[c] = o_func[c] | i_active[t]; // [RULE17]
            end
        end
    end
endmodule

//--- rtl/in_router_edge.sv
// Rise and fall pulse detector for one-shot functions
`timescale 1ns/1ns
module in_router_edge
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_level,
    output logic o_rise,
    output logic o_fall
);
    logic level_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            level_r <= 1'b0;
        else
            level_r <= i_level;
    end

    assign o_rise = i_level & ~level_r;
    assign o_fall = ~i_level & level_r;
endmodule

//--- verif/term_ctrl_model.sv
// Controller model that drives the eight input terminals
`timescale 1ns/1ns
module term_ctrl_model
    import in_router_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic [NUM_TERM-1:0] i_level_req,
    output logic [NUM_TERM-1:0] o_input_terminal
);
    // Contacts switch just after an edge
    always_ff @(posedge i_sys_clk)
    begin
        o_input_terminal <= i_level_req;
    end
endmodule

//--- verif/in_router_sva.sv
// Checker for the router's bus answers and one-shot outputs
`timescale 1ns/1ns
module in_router_sva
    import in_router_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hsel,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire logic o_alarm_clear,
    input wire logic o_position_preset,
    input wire logic o_abs_error_clear,
    input wire logic [NUM_GENERAL-1:0] o_general_signal,
    input wire logic [NUM_DATA_SEL-1:0] o_data_select
);
    logic rd;
    assign rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    property p_rdy; o_hreadyout; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state seen");
    property p_okay; !o_hresp; endproperty
    a_okay: assert property (p_okay) else $error("error response");
    property p_alm; o_alarm_clear |=> !o_alarm_clear; endproperty
    a_alm: assert property (p_alm) else $error("alarm clear too long");
    property p_pre; o_position_preset |=> !o_position_preset; endproperty
    a_pre: assert property (p_pre) else $error("preset too long");
    property p_abs; o_abs_error_clear |=> !o_abs_error_clear; endproperty
    a_abs: assert property (p_abs) else $error("abs clear too long");
    property p_unm; rd && i_haddr >= 32'h18 && i_haddr < 32'h100 |=> o_hrdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_sts; rd && i_haddr == 32'h10 |=> o_hrdata[5:0] == $past(o_data_select);
    endproperty
    a_sts: assert property (p_sts) else $error("status data select");
    property p_gen; rd && i_haddr == 32'h14 |=> o_hrdata[15:0] == $past(o_general_signal);
    endproperty
    a_gen: assert property (p_gen) else $error("general readback");
endmodule
bind input_terminal_function_router in_router_sva i_sva (.i_sys_clk, .i_rst_n, .i_haddr,
    .i_htrans, .i_hwrite, .i_hsel, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .o_alarm_clear, .o_position_preset, .o_abs_error_clear, .o_general_signal, .o_data_select);

//--- verif/input_terminal_function_router_bench.sv
// Self-checking bench for the input terminal function router
`timescale 1ns/1ns
module input_terminal_function_router_bench import in_router_pkg::*;;
    logic i_sys_clk = 0, i_rst_n = 0, i_hwrite = 0, i_hsel = 0, i_remote_valid = 0;
    logic [1:0] i_htrans = 0;
    logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rdv;
    logic [7:0] lvl_req = 0, i_input_terminal;
    logic [63:0] i_remote_func = 0;
    logic o_hreadyout, o_hresp, cp, cn, hm, ps, sq, ip, ineg, fr, ex, ht, ac, pp, ae, lr;
    logic [5:0] dps, dsel;
    logic [15:0] gs;
    logic [38:0] obs;
    int err_total = 0, checks = 0;
    assign obs = {cp, cn, hm, ps, sq, ip, ineg, dps, fr, ht, gs, dsel, ex, lr};
    input_terminal_function_router i_dut (.i_sys_clk, .i_rst_n, .i_input_terminal,
        .i_remote_valid, .i_remote_func, .i_haddr, .i_htrans, .i_hwrite, .i_hsize(3'h2),
        .i_hwdata, .i_hsel, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp,
        .o_cont_positive_req(cp), .o_cont_negative_req(cn), .o_home_req(hm),
        .o_position_req(ps), .o_sequential_pos_req(sq), .o_inch_positive_req(ip),
        .o_inch_negative_req(ineg), .o_direct_pos_select(dps), .o_free_run(fr),
        .o_excitation_on(ex), .o_halt(ht), .o_alarm_clear(ac), .o_position_preset(pp),
        .o_abs_error_clear(ae), .o_lockout_release(lr), .o_general_signal(gs),
        .o_data_select(dsel));
    term_ctrl_model i_ctrl (.i_sys_clk, .i_level_req(lvl_req),
        .o_input_terminal(i_input_terminal));
    initial
    begin
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_hsel <= 1;
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= wr;
        i_haddr <= a;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 0;
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        rdv = o_hrdata;
    endtask
    // Write, then read the same word in the very next address phase
    task automatic wr_rd(input logic [31:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_hsel <= 1;
        i_htrans <= HTRANS_NONSEQ;
        i_hwrite <= 1;
        i_haddr <= a;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        i_hwrite <= 0;
        i_hwdata <= d;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        i_hsel <= 0;
        i_htrans <= 2'h0;
        do @(posedge i_sys_clk); while (o_hreadyout !== 1'b1);
        rdv = o_hrdata;
    endtask
    task automatic drive(input logic [7:0] v);
        @(posedge i_sys_clk);
        lvl_req <= v;
        repeat (3) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic pulses(input logic [7:0] v, output int np, output int na, output int nb);
        np = 0;
        na = 0;
        nb = 0;
        @(posedge i_sys_clk);
        lvl_req <= v;
        repeat (6)
        begin
            @(posedge i_sys_clk);
            #1;
            np += pp;
            na += ac;
            nb += ae;
        end
    endtask
    function automatic logic [38:0] exp_obs(input int c, input logic lv);
        logic [63:0] f;
        f = lv ? 64'h1 << c : 64'h0;
        return {f[1], f[2], f[3], f[4], f[5], f[6], f[7], f[13:8], f[16], f[18], f[47:32],
            f[53:48], (c == 17) ? lv : 1'b1, (c == 27) ? lv : 1'b1};
    endfunction
    task automatic t_reset();
        bus(0, ADDR_CODE_LO, 0);
        chk("codes_lo", rdv, 32'h31300403);
        bus(0, ADDR_CODE_HI, 0);
        chk("codes_hi", rdv, 32'h18121032);
        bus(0, ADDR_POLARITY, 0);
        chk("polarity", rdv, 0);
        drive(8'h6e);
        chk("defaults", {hm, ps, dsel, fr, ht, ex, lr}, {2'b01, 6'h03, 4'hf});
        bus(0, ADDR_STATUS, 0);
        chk("status", rdv[15:0], 16'h6e03);
        bus(0, 32'h40, 0);
        chk("unmapped", rdv, 0);
        drive(0);
        $display("t_reset done");
    endtask
    task automatic t_codes();
        int cl[22] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 13, 14, 16, 17, 18, 19, 27, 28, 32,
            47, 48, 53, 54};
        bus(1, ADDR_CODE_HI, 0);
        foreach (cl[k])
        begin
            bus(1, ADDR_CODE_LO, cl[k]);
            drive(1);
            chk("func_on", obs, exp_obs(cl[k], 1));
            drive(0);
            chk("func_off", obs, exp_obs(cl[k], 0));
        end
        $display("t_codes done");
    endtask
    task automatic t_pol();
        bus(1, ADDR_CODE_LO, 32'h0101);
        wr_rd(ADDR_POLARITY, 1);
        chk("pol_forward", rdv, 1);
        drive(0);
        chk("inverted", cp, 1);
        drive(8'h01);
        chk("released", cp, 0);
        drive(8'h03);
        chk("either", cp, 1);
        bus(1, ADDR_POLARITY, 0);
        drive(0);
        $display("t_pol done");
    endtask
    task automatic t_edges();
        int np, na, nb;
        bus(1, ADDR_CODE_LO, 32'h00181a19);
        pulses(8'h07, np, na, nb);
        chk("preset_rise", np, 1);
        chk("clear_rise", na + nb, 0);
        pulses(8'h00, np, na, nb);
        chk("preset_fall", np, 0);
        chk("alarm_fall", na, 1);
        chk("abs_fall", nb, 1);
        $display("t_edges done");
    endtask
    task automatic t_remote();
        bus(1, ADDR_CODE_LO, 32'h11);
        wr_rd(ADDR_REMOTE, 1);
        chk("remote_en", rdv, 1);
        @(posedge i_sys_clk);
        i_remote_func <= 64'h0000_0001_0004_0000;
        i_remote_valid <= 1;
        @(posedge i_sys_clk);
        i_remote_valid <= 0;
        drive(8'h01);
        chk("remote_halt", ht, 1);
        chk("excite_and", ex, 0);
        chk("remote_gen", gs, 16'h0001);
        bus(0, ADDR_GENERAL, 0);
        chk("gen_read", rdv, 1);
        $display("t_remote done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge i_sys_clk);
        i_rst_n <= 1;
        t_reset();
        t_codes();
        t_pol();
        t_edges();
        t_remote();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        err_total++;
        report_and_stop();
    end
endmodule
